// ===== include/cgd_map.svh
// Register offsets, field positions, reset values and field widths of the clock generator
`ifndef CGD_MAP_SVH
`define CGD_MAP_SVH
`define CGD_OFS_FREQ_A      8'h20
`define CGD_OFS_FREQ_B      8'h24
`define CGD_OFS_CLKSRC      8'h28
`define CGD_OFS_CPUPLL      8'h60
`define CGD_OFS_AUXPLL      8'h64
`define CGD_OFS_SYSCFG      8'h70
`define CGD_OFS_STATUS      8'h74
`define CGD_RST_FREQ        32'h0000_0000
`define CGD_RST_CLKSRC      32'h0000_0000
`define CGD_RST_CPUPLL      32'h0000_0010
`define CGD_RST_AUXPLL      32'h0000_0000
`define CGD_RST_SYSCFG      32'h0000_0002
`define CGD_GEN_STRIDE      10
`define CGD_DIV_LSB         2
`define CGD_FE_BIT          1
`define CGD_FS_BIT          0
`define CGD_ME1_LSB         27
`define CGD_DE1_BIT         26
`define CGD_CE1_BIT         25
`define CGD_ME0_LSB         22
`define CGD_DE0_BIT         21
`define CGD_CE0_BIT         20
`define CGD_SD_LSB          0
`define CGD_CR_BIT          2
`define CGD_PF_FS3_BIT      3
`define CGD_PF_EXT0_BIT     4
`define CGD_PF_EXT1_BIT     5
`define CGD_PLL_W           6
`endif

// ===== include/cgd_pkg.sv
// Types shared by the clock generator
package cgd_pkg;
    typedef struct packed {
        logic [7:0] divider;
        logic       out_enable;
        logic       source;
    } cgd_gen_t;

    typedef struct packed {
        logic [2:0] mux_select;
        logic       divide_select;
        logic       divider_bypass;
    } cgd_sel_t;

    typedef enum logic [1:0] {
        CGD_BUS_IDLE,
        CGD_BUS_ACK
    } cgd_bus_t;
endpackage : cgd_pkg

// ===== core/cgd_clock_gen.sv
// Clock generator: frequency generators, source selectors, bus clock derivation
//
// Contract
// - Generator divides its source by two times divider field plus one.
// - Output enable bit above source bit; 0 blocks, 1 passes divided clock.
// - Source select 0 takes CPU clock, 1 takes auxiliary clock.
// - Generator three alternate source: pin-function bit picks aux or GPIO 23.
// - Six generators plus aux clock feed every peripheral and external selector; aux enters as a level flag, high while the aux multiplier is nonzero.
// - Generator and source registers reset only on hardware reset.
// - Aux PLL register resets on both resets; CPU PLL only on hardware.
// - System bus clock is CPU clock divided by 2, 3 or 4.
// - Peripheral bus clock is system bus clock divided by two.
// - Memory clock is system clock or half, ratio setting 1 or 2.
// - Source register bits 29:27 select external clock one source.
// - PLLs and generator run from the 12 MHz oscillator only.
// - External clocks reach shared GPIO pins only when pin function selects.
// - Mux select: 000 none, 001 aux, 010..111 generators zero to five.
// - Clock select 0 passes mux; 1 adds divider, 4 or 2.
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
`include "cgd_map.svh"

module cgd_clock_gen
    import cgd_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_runtime_rstn,
    input  wire logic        i_cpu_clk_en,
    input  wire logic        i_aux_clk_en,
    input  wire logic        i_gpio23,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic      [5:0]  o_gen_clk,
    output logic             o_ext0_clk,
    output logic             o_ext1_clk,
    output logic             o_ext0_oe,
    output logic             o_ext1_oe,
    output logic             o_serial0_clk,
    output logic             o_serial1_clk,
    output logic             o_sysbus_clk,
    output logic             o_periph_clk,
    output logic             o_mem_clk,
    output logic      [5:0]  o_cpu_pll_mult,
    output logic      [5:0]  o_aux_pll_mult
);
    // Registers
    logic [31:0] freq_a_reg;
    logic [31:0] freq_b_reg;
    logic [31:0] clksrc_reg;
    logic [31:0] cpupll_reg;
    logic [31:0] auxpll_reg;
    logic [31:0] syscfg_reg;
    logic [31:0] rdata_reg;
    cgd_bus_t    bus_reg;
    logic [1:0]  gpio_sync_reg;
    logic [1:0]  rt_sync_reg;

    // Bus decode
    wire         req      = avs_read | avs_write;
    wire         take     = req & (bus_reg == CGD_BUS_IDLE);
    // Write lands on the answer edge, while the master still holds the request
    wire         wr       = avs_write & (bus_reg == CGD_BUS_ACK);
    wire [31:0]  bmask    = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                             {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire         hit_a    = avs_address == `CGD_OFS_FREQ_A;
    wire         hit_b    = avs_address == `CGD_OFS_FREQ_B;
    wire         hit_src  = avs_address == `CGD_OFS_CLKSRC;
    wire         hit_cpu  = avs_address == `CGD_OFS_CPUPLL;
    wire         hit_aux  = avs_address == `CGD_OFS_AUXPLL;
    wire         hit_cfg  = avs_address == `CGD_OFS_SYSCFG;
    wire         hit_st   = avs_address == `CGD_OFS_STATUS;
    wire         rt_rst   = ~rt_sync_reg[1];
    wire         gpio23_s = gpio_sync_reg[1];

    // Generator outputs and status, declared for the read mux
    logic [5:0]  gen_out;
    logic [5:0]  gen_run;
    wire  [31:0] status_w = {18'h0, gen_run, 2'h0, gen_out};

    wire  [31:0] rmux =
        hit_a   ? (freq_a_reg & 32'h3fff_ffff) :
        hit_b   ? (freq_b_reg & 32'h3fff_ffff) :
        hit_src ? (clksrc_reg & 32'h3ff0_001f) :
        hit_cpu ? cpupll_reg :
        hit_aux ? auxpll_reg :
        hit_cfg ? (syscfg_reg & 32'h0000_003f) :
        hit_st  ? status_w : 32'h0;

    assign avs_waitrequest = req & (bus_reg == CGD_BUS_IDLE);
    assign avs_readdata    = rdata_reg;

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            bus_reg   <= CGD_BUS_IDLE;
            rdata_reg <= 32'h0;
        end
        else
        begin
            bus_reg   <= take ? CGD_BUS_ACK : CGD_BUS_IDLE;
            rdata_reg <= (take & avs_read) ? rmux : rdata_reg;
        end
    end

    // Hardware reset only; runtime reset does not touch these
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            freq_a_reg <= `CGD_RST_FREQ;
            freq_b_reg <= `CGD_RST_FREQ;
            clksrc_reg <= `CGD_RST_CLKSRC;
            cpupll_reg <= `CGD_RST_CPUPLL;
            syscfg_reg <= `CGD_RST_SYSCFG;
        end
        else
        begin
            if (wr & hit_a)
                freq_a_reg <= (freq_a_reg & ~bmask) | (avs_writedata & bmask);
            if (wr & hit_b)
                freq_b_reg <= (freq_b_reg & ~bmask) | (avs_writedata & bmask);
            if (wr & hit_src)
                clksrc_reg <= (clksrc_reg & ~bmask) | (avs_writedata & bmask);
            if (wr & hit_cpu)
                cpupll_reg <= (cpupll_reg & ~bmask) | (avs_writedata & bmask);
            if (wr & hit_cfg)
                syscfg_reg <= (syscfg_reg & ~bmask) | (avs_writedata & bmask);
        end
    end

    // Aux multiplier also returns to default on runtime reset
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            auxpll_reg <= `CGD_RST_AUXPLL;
        else if (rt_rst)
            auxpll_reg <= `CGD_RST_AUXPLL;
        else if (wr & hit_aux)
            auxpll_reg <= (auxpll_reg & ~bmask) | (avs_writedata & bmask);
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            gpio_sync_reg <= 2'h0;
            rt_sync_reg   <= 2'h0;
        end
        else
        begin
            gpio_sync_reg <= {gpio_sync_reg[0], i_gpio23};
            rt_sync_reg   <= {rt_sync_reg[0], i_runtime_rstn};
        end
    end

    assign o_cpu_pll_mult = cpupll_reg[`CGD_PLL_W-1:0];
    assign o_aux_pll_mult = auxpll_reg[`CGD_PLL_W-1:0];

    // Sources are enables on the 12 MHz-derived i_clk; GPIO 23 becomes an edge pulse
    logic        gpio_prev_reg;
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            gpio_prev_reg <= 1'b0;
        else
            gpio_prev_reg <= gpio23_s;
    end
    wire         gpio_tick = gpio23_s & ~gpio_prev_reg;
    wire  [59:0] gen_fields = {freq_b_reg[29:0], freq_a_reg[29:0]};

    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1)
        begin : gen_freq
            cgd_gen_t    cfg;
            logic [7:0]  cnt_reg;
            logic [7:0]  div_reg;
            logic        src_reg;
            logic        en_reg;
            logic        out_reg;
            logic        tick;
            assign cfg = gen_fields[g*`CGD_GEN_STRIDE +: `CGD_GEN_STRIDE];
            if (g == 3)
            begin : alt
                assign tick = src_reg ? (syscfg_reg[`CGD_PF_FS3_BIT] ? gpio_tick
                                                                    : i_aux_clk_en)
                                      : i_cpu_clk_en;
            end
            else
            begin : std
                assign tick = src_reg ? i_aux_clk_en : i_cpu_clk_en;
            end
            // Settings latch at the low-phase end, or on any cycle while disabled, so no runt half period
            wire wrap = tick & (cnt_reg == div_reg);
            wire load = ~out_reg & (wrap | ~en_reg);
            always_ff @(posedge i_clk or negedge i_rstn)
            begin
                if (!i_rstn)
                begin
                    cnt_reg <= 8'h0;
                    div_reg <= 8'h0;
                    src_reg <= 1'b0;
                    en_reg  <= 1'b0;
                    out_reg <= 1'b0;
                end
                else
                begin
                    if (load)
                    begin
                        div_reg <= cfg.divider;
                        src_reg <= cfg.source;
                        en_reg  <= cfg.out_enable;
                    end
                    if (!en_reg)
                    begin
                        cnt_reg <= 8'h0;
                        out_reg <= 1'b0;
                    end
                    else if (tick)
                    begin
                        // Half period is divider+1 ticks: total 2*(d+1)
                        cnt_reg <= wrap ? 8'h0 : cnt_reg + 8'h1;
                        // A low-phase end only rises if the newly latched enable allows it
                        out_reg <= wrap ? (~out_reg & cfg.out_enable) : out_reg;
                    end
                end
            end
            assign gen_out[g] = out_reg;
            assign gen_run[g] = en_reg;
        end
    endgenerate

    // Clock source selectors, 0 = external clock 0, 1 = external clock 1
    cgd_sel_t    sel [2];
    logic [1:0]  sel_clk;
    assign sel[0] = clksrc_reg[`CGD_ME0_LSB+2:`CGD_CE0_BIT];
    assign sel[1] = clksrc_reg[`CGD_ME1_LSB+2:`CGD_CE1_BIT];
    wire  [7:0]  cands = {gen_out, o_aux_pll_mult != 6'h0 ? 1'b1 : 1'b0, 1'b0};

    generate
        for (g = 0; g < 2; g = g + 1)
        begin : gen_sel
            logic       mux_prev_reg;
            logic [1:0] div_cnt_reg;
            wire        mux_out = cands[sel[g].mux_select];
            always_ff @(posedge i_clk or negedge i_rstn)
            begin
                if (!i_rstn)
                begin
                    mux_prev_reg <= 1'b0;
                    div_cnt_reg  <= 2'h0;
                end
                else
                begin
                    mux_prev_reg <= mux_out;
                    if (mux_out & ~mux_prev_reg)
                        div_cnt_reg <= div_cnt_reg + 2'h1;
                end
            end
            // Bit 0 toggles every rising edge: div 2; bit 1: div 4
            wire divd = sel[g].divide_select ? div_cnt_reg[0] : div_cnt_reg[1];
            assign sel_clk[g] = sel[g].divider_bypass ? divd : mux_out;
        end
    endgenerate

    // Aux selection is a level flag here, so the aux source reads as steady high while the aux multiplier is nonzero, low otherwise
    assign o_gen_clk     = gen_out;
    assign o_serial0_clk = sel_clk[0];
    assign o_serial1_clk = sel_clk[1];
    assign o_ext0_clk    = sel_clk[0];
    assign o_ext1_clk    = sel_clk[1];
    assign o_ext0_oe     = syscfg_reg[`CGD_PF_EXT0_BIT];
    assign o_ext1_oe     = syscfg_reg[`CGD_PF_EXT1_BIT];

    // Bus clocks derived from i_clk, which stands for the CPU clock
    logic [1:0]  sd_cnt_reg;
    logic        sys_reg;
    logic        per_reg;
    logic        mem_reg;
    wire  [1:0]  sd_val  = syscfg_reg[`CGD_SD_LSB+1:`CGD_SD_LSB];
    // Two bits cannot hold 4, so field value 0 stands for it; 1 is taken as 2
    wire  [2:0]  sd_div  = (sd_val == 2'h0) ? 3'h4 : (sd_val == 2'h1) ? 3'h2 : {1'b0, sd_val};
    wire         sys_end = {1'b0, sd_cnt_reg} == sd_div - 3'h1;
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            sd_cnt_reg <= 2'h0;
            sys_reg    <= 1'b0;
            per_reg    <= 1'b0;
            mem_reg    <= 1'b0;
        end
        else
        begin
            sd_cnt_reg <= sys_end ? 2'h0 : sd_cnt_reg + 2'h1;
            sys_reg    <= {1'b0, sd_cnt_reg} < (sd_div >> 1);
            if (sys_end)
                per_reg <= ~per_reg;
            if (sys_end)
                mem_reg <= syscfg_reg[`CGD_CR_BIT] ? ~mem_reg : 1'b1;
        end
    end
    assign o_sysbus_clk = sys_reg;
    assign o_periph_clk = per_reg;
    // Ratio 1 follows system clock; ratio 2 halves it
    assign o_mem_clk    = syscfg_reg[`CGD_CR_BIT] ? mem_reg : sys_reg;
endmodule : cgd_clock_gen
`default_nettype wire

// ===== verif/cgd_clock_gen_checker.sv
// Port-level concurrent checks for the clock generator
`timescale 1ns/100ps
`default_nettype none
`include "cgd_map.svh"

module cgd_clock_gen_checker (
    input wire logic        i_clk,
    input wire logic        i_rstn,
    input wire logic        i_runtime_rstn,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic        avs_waitrequest,
    input wire logic [5:0]  o_gen_clk,
    input wire logic        o_sysbus_clk,
    input wire logic        o_periph_clk,
    input wire logic [5:0]  o_cpu_pll_mult,
    input wire logic [5:0]  o_aux_pll_mult
);
    // Shadow of control A; off time saturates past the longest period
    logic [31:0] shadow_reg;
    logic [9:0]  off_reg;
    wire         wr_a = avs_write && !avs_waitrequest && avs_address == `CGD_OFS_FREQ_A;

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            shadow_reg <= 32'h0;
            off_reg    <= 10'h0;
        end
        else
        begin
            shadow_reg <= wr_a ? avs_writedata : shadow_reg;
            off_reg    <= shadow_reg[1] ? 10'h0 : off_reg + {9'h0, off_reg != 10'h3ff};
        end
    end

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    property p_hw_defaults;
        $rose(i_rstn) |-> o_gen_clk == 6'h0 && o_cpu_pll_mult == 6'h10 && o_aux_pll_mult == 6'h0;
    endproperty
    a_hw_defaults: assert property (p_hw_defaults) else $error("reset values wrong");
    property p_aux_clear;
        $fell(i_runtime_rstn) |-> ##[2:4] o_aux_pll_mult == 6'h0;
    endproperty
    a_aux_clear: assert property (p_aux_clear) else $error("aux pll not cleared");
    property p_aux_held;
        !i_runtime_rstn [*5] |-> o_aux_pll_mult == 6'h0;
    endproperty
    a_aux_held: assert property (p_aux_held) else $error("aux pll not held");
    property p_cpu_keep;
        !i_runtime_rstn && !avs_write |=> $stable(o_cpu_pll_mult);
    endproperty
    a_cpu_keep: assert property (p_cpu_keep) else $error("cpu pll lost");
    property p_periph_half;
        $changed(o_periph_clk) |=> $stable(o_periph_clk);
    endproperty
    a_periph_half: assert property (p_periph_half) else $error("periph too fast");
    property p_sys_rate;
        $rose(o_sysbus_clk) |-> ##[2:4] $rose(o_sysbus_clk);
    endproperty
    a_sys_rate: assert property (p_sys_rate) else $error("sysbus rate wrong");
    property p_gen_off;
        off_reg == 10'h3ff |-> !o_gen_clk[0];
    endproperty
    a_gen_off: assert property (p_gen_off) else $error("disabled gen not low");
    property p_ack;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_ack: assert property (p_ack) else $error("no bus answer");

    c_runtime: cover property ($fell(i_runtime_rstn));
    c_gen3: cover property ($rose(o_gen_clk[3]));
    c_read: cover property (avs_read && !avs_waitrequest);
endmodule : cgd_clock_gen_checker

bind cgd_clock_gen cgd_clock_gen_checker u_chk (.*);
`default_nettype wire

// ===== verif/cgd_clk_sink.sv
// Clock consumer model: measures period and counts rising edges
`timescale 1ns/100ps
`default_nettype none
module cgd_clk_sink (
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_clk_in,
    output logic      [15:0] o_period,
    output logic      [15:0] o_edges
);
    logic        prev_reg;
    logic [15:0] cnt_reg;
    wire         rise = i_clk_in && !prev_reg;

    // Accepts any rate; keeping pins slow is up to software
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            prev_reg <= 1'b0;
            cnt_reg  <= 16'h0;
            o_period <= 16'h0;
            o_edges  <= 16'h0;
        end
        else
        begin
            prev_reg <= i_clk_in;
            cnt_reg  <= rise ? 16'h0 : cnt_reg + 16'h1;
            o_period <= rise ? cnt_reg + 16'h1 : o_period;
            o_edges  <= o_edges + {15'h0, rise};
        end
    end
endmodule : cgd_clk_sink
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the clock generator
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [3:0] s; logic [15:0] p;} cgd_row_t;
    logic        i_clk = 1'b0, i_rstn = 1'b0, i_runtime_rstn = 1'b1, i_gpio23 = 1'b0;
    logic        i_cpu_clk_en = 1'b1, i_aux_clk_en = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [7:0]  avs_address = 8'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic [3:0]  avs_byteenable = 4'hf, sel = 4'h0;
    logic [5:0]  o_gen_clk, o_cpu_pll_mult, o_aux_pll_mult;
    logic        avs_waitrequest, o_ext0_clk, o_ext1_clk, o_ext0_oe, o_ext1_oe, o_serial0_clk;
    logic        o_serial1_clk, o_sysbus_clk, o_periph_clk, o_mem_clk;
    logic [15:0] per, edges, e0;
    logic [1:0]  gcnt = 2'h0;
    int          mismatches = 0, num_checks = 0;
    wire  [12:0] taps = {o_serial0_clk, o_mem_clk, o_periph_clk, o_sysbus_clk, o_ext0_clk,
                         o_serial1_clk, o_ext1_clk, o_gen_clk};
    wire         tap = taps[sel];
    // Periods in cycles; cpu ticks every cycle, aux every second, gpio rises every sixth
    cgd_row_t rows [21] = '{
        '{8'h20, 32'h2, 4'h0, 16'h2}, '{8'h20, 32'ha, 4'h0, 16'h6}, '{8'h20, 32'h7, 4'h0, 16'h8},
        '{8'h20, 32'h3800, 4'h1, 16'h8}, '{8'h20, 32'h600000, 4'h2, 16'h4},
        '{8'h24, 32'h2, 4'h3, 16'h2}, '{8'h24, 32'ha00000, 4'h5, 16'h6},
        '{8'h20, 32'h2, 4'h0, 16'h2}, '{8'h28, 32'h10000000, 4'h6, 16'h2},
        '{8'h28, 32'h16000000, 4'h6, 16'h4}, '{8'h28, 32'h12000000, 4'h6, 16'h8},
        '{8'h28, 32'h38000000, 4'h7, 16'h6}, '{8'h28, 32'h800000, 4'h8, 16'h2},
        '{8'h28, 32'h800000, 4'hc, 16'h2},
        '{8'h70, 32'h3, 4'h9, 16'h3}, '{8'h70, 32'h3, 4'ha, 16'h6}, '{8'h70, 32'h3, 4'hb, 16'h3},
        '{8'h70, 32'h6, 4'hb, 16'h4}, '{8'h70, 32'h0, 4'h9, 16'h4}, '{8'h70, 32'ha, 4'h9, 16'h2},
        '{8'h24, 32'h3, 4'h3, 16'hc}};

    cgd_clock_gen DUT (.*);
    cgd_clk_sink u_sink (.i_clk(i_clk), .i_rstn(i_rstn), .i_clk_in(tap), .o_period(per),
                         .o_edges(edges));

    always #25 i_clk = !i_clk;
    always @(posedge i_clk)
    begin
        i_aux_clk_en <= !i_aux_clk_en;
        gcnt <= (gcnt == 2'h2) ? 2'h0 : gcnt + 2'h1;
        i_gpio23 <= (gcnt == 2'h2) ? !i_gpio23 : i_gpio23;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= rd;
        avs_write <= !rd;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        // Answer edge: take read data here, then release
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0)
        begin
            mismatches++;
            close_out();
        end
    endtask : bus

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b1, a, 32'h0);
        chk(q, exp);
    endtask : rdchk

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out

    initial
    begin
        repeat (20000) @(posedge i_clk);
        mismatches++;
        close_out();
    end

    initial
    begin
        repeat (2) @(posedge i_clk);
        i_rstn <= 1'b1;
        bus(1'b0, 8'h40, 32'hffff_ffff);
        rdchk(8'h40, 32'h0);
        rdchk(8'h20, 32'h0);
        rdchk(8'h28, 32'h0);
        rdchk(8'h60, 32'h10);
        $display("test reset done");
        foreach (rows[i])
        begin
            bus(1'b0, rows[i].a, rows[i].d);
            sel <= rows[i].s;
            rdchk(rows[i].a, rows[i].d);
            // Settle, then count rises over 48 cycles: every period here divides 48
            repeat (24) @(posedge i_clk);
            e0 = edges;
            repeat (48) @(posedge i_clk);
            chk({16'h0, per}, {16'h0, rows[i].p});
            chk({16'h0, edges - e0}, 32'h30 / {16'h0, rows[i].p});
            $display("test row %0d done", i);
        end
        // Mux select left at zero by the last source write: no clock
        sel <= 4'h6;
        repeat (20) @(posedge i_clk);
        e0 = edges;
        repeat (40) @(posedge i_clk);
        chk({16'h0, edges}, {16'h0, e0});
        bus(1'b0, 8'h64, 32'hc);
        bus(1'b0, 8'h60, 32'h20);
        chk({26'h0, o_aux_pll_mult}, 32'hc);
        i_runtime_rstn <= 1'b0;
        repeat (6) @(posedge i_clk);
        i_runtime_rstn <= 1'b1;
        rdchk(8'h64, 32'h0);
        rdchk(8'h60, 32'h20);
        rdchk(8'h24, 32'h3);
        rdchk(8'h28, 32'h800000);
        $display("test runtime reset done");
        bus(1'b0, 8'h70, 32'h30);
        @(posedge i_clk);
        chk({30'h0, o_ext1_oe, o_ext0_oe}, 32'h3);
        bus(1'b0, 8'h70, 32'h0);
        @(posedge i_clk);
        chk({30'h0, o_ext1_oe, o_ext0_oe}, 32'h0);
        bus(1'b0, 8'h20, 32'h0);
        repeat (1100) @(posedge i_clk);
        chk({31'h0, o_gen_clk[0]}, 32'h0);
        $display("test pins and disable done");
        close_out();
    end
endmodule : tb_top
`default_nettype wire
